// ==== shared/dips_pkg.sv ====
// Package for the display idle / general power-down sequencer: map, fields, types
package dips_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] REFRESH_INTERVAL_CTRL_OFS = 8'h00;
	localparam logic [7:0] POWER_MODE_CTRL_OFS       = 8'h01;
	localparam logic [7:0] PANEL_OUTPUT_CTRL_OFS     = 8'h02;
	localparam logic [7:0] PANEL_POWER_CTRL_OFS      = 8'h03;
	localparam logic [7:0] REFRESH_COUNT_CTRL_OFS    = 8'h04;
	localparam logic [7:0] VRETRACE_END_OFS          = 8'h05;
	localparam logic [7:0] PD_STATUS_OFS             = 8'h06;
	localparam logic [7:0] SWEEP_COUNT_OFS           = 8'h07;

	// Field positions
	localparam int GENERAL_MODE_BIT = 7;  // refresh_interval_ctrl
	localparam int INTERVAL_MSB     = 6;  // refresh_interval_ctrl[6:0]
	localparam int SUSPEND_SEL_BIT  = 7;  // power_mode_ctrl
	localparam int DIVIDE_EN_BIT    = 6;  // power_mode_ctrl
	localparam int PANEL_TRI_BIT    = 5;  // panel_output_ctrl
	localparam int PANEL_PWR_BIT    = 2;  // panel_power_ctrl
	localparam int REF_CNT_MSB      = 1;  // refresh_count_ctrl[1:0]
	localparam int VRE_REF5_BIT     = 6;  // vretrace_end

	// Reset values
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// Timing counts
	localparam logic [1:0] ENTRY_EXIT_COUNT = 2'h2;  // retraces and refreshes to wait
	localparam logic [1:0] FRAME_PULSE_COUNT = 2'h2;
	localparam logic [2:0] SLOW_DIVIDE_LAST  = 3'h7;  // divide by eight
	localparam logic [2:0] MCLK_PER_CYCLE_LAST = 3'h5; // six memory clocks per cycle
	localparam logic [7:0] INTERVAL_OFFSET   = 8'h05;
	localparam int DOTS_PER_CHAR = 8;
	localparam int REFRESH_ROWS  = 512;

	// Sequencer states
	typedef enum logic [2:0] {ST_RUN, ST_ENTER, ST_PD, ST_EXIT, ST_FPW} dips_state_t;

	// Flat panel output control bundle
	typedef struct packed {
		logic oe;         // High while panel pins are driven
		logic force_low;  // Driven pins held low instead of normal data
		logic active;     // Normal panel control and data activity
	} dips_panel_t;

	// Host access gates
	typedef struct packed {
		logic reg_allow;
		logic mem_allow;
		logic pal_allow;  // Palette and mapping RAM
	} dips_access_t;

	// Refresh cycles per operation from the count field and the retrace-end bit
	function automatic logic [2:0] refresh_cycles(input logic [1:0] cnt, input logic five);
		if (five)
			return 3'h5;
		case (cnt)
			2'h0:    return 3'h1;
			2'h1:    return 3'h2;
			default: return 3'h3;
		endcase
	endfunction : refresh_cycles

endpackage : dips_pkg

// ==== rtl/dips_refresh_pacer.sv ====
// Refresh operation pacer for general power-down mode
`timescale 1ns/1ps
module dips_refresh_pacer #(
	parameter int DOTS_PER_CHAR = dips_pkg::DOTS_PER_CHAR
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic [6:0] interval,
	input  wire logic [2:0] burst_cycles,
	// Results
	output logic            refresh_strobe,
	output logic            refresh_window,
	output logic            busy
);
	logic [2:0] dot_q;
	logic [7:0] char_q;
	logic [2:0] slot_q;
	logic [2:0] left_q;
	logic       setup_q;
	logic [7:0] period_w;
	logic       op_start_w;

	assign period_w   = {1'b0, interval} + dips_pkg::INTERVAL_OFFSET;
	assign op_start_w = tick && dot_q == 3'h0 && char_q == 8'h00;
	assign busy       = setup_q || left_q != 3'h0;

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			dot_q  <= 3'h0;
			char_q <= 8'h00;
		end else if (tick) begin
			dot_q <= (dot_q == 3'(DOTS_PER_CHAR - 1)) ? 3'h0 : dot_q + 3'h1;
			if (dot_q == 3'(DOTS_PER_CHAR - 1))
				char_q <= (char_q >= period_w - 8'h01) ? 8'h00 : char_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			setup_q        <= 1'b0;
			slot_q         <= 3'h0;
			left_q         <= 3'h0;
			refresh_strobe <= 1'b0;
		end else begin
			refresh_strobe <= 1'b0;
			if (op_start_w && !busy) begin
				setup_q <= 1'b1;
				slot_q  <= 3'h0;
				left_q  <= burst_cycles;
			end else if (tick && busy) begin
				slot_q <= (slot_q == dips_pkg::MCLK_PER_CYCLE_LAST) ? 3'h0 : slot_q + 3'h1;
				if (slot_q == dips_pkg::MCLK_PER_CYCLE_LAST) begin
					if (setup_q) begin
						setup_q        <= 1'b0;
						refresh_strobe <= left_q != 3'h0;
					end else begin
						left_q         <= left_q - 3'h1;
						refresh_strobe <= left_q > 3'h1;
					end
				end
			end
		end
	end

	// first half of the period refreshes
	always_ff @(posedge clk) begin
		if (sys_rst || !run)
			refresh_window <= 1'b0;
		else
			refresh_window <= char_q < (period_w >> 1);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_strobe_gap: assert property (refresh_strobe |=> !refresh_strobe [*5])
		else $error("refresh strobes closer than six clocks");
	c_strobe: cover property (refresh_strobe ##[1:200] refresh_strobe);

endmodule : dips_refresh_pacer

// ==== rtl/dips_sequencer.sv ====
// Display idle and general power-down sequencer with its registers
//
// Functional notes
// - General mode divides clocks only when enabled
// - Request fall: LCD enable off, DAC off
// - After two retraces/refreshes: divide, alternate refresh
// - Panel power bit drives power-off pin inverted
// - Untristated panel pins driven low before exit
// - Request rise restores full clock rate
// - Two refreshes/retraces later panel activity resumes
// - Two frame pulses later LCD enable active
// - Idle: registers yes, palette/mapping/memory no
// - Idle: refresh follows external refresh input
// - General: registers and memory yes, palette no
// - General: interval field paces refresh operations
// - Refresh sweep covers 512 rows
// - One, two, three or five cycles per operation
// - Six memory clocks per cycle, six setup
// - Operation period is char times interval+5
// - Half the period refreshes, rest serves host
// - Clock synthesizer keeps running in both modes
`timescale 1ns/1ps
module dips_sequencer (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// Register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [7:0]            reg_rdata,
	// Power manager and timing inputs
	input  wire logic                  powerdown_request_n,
	input  wire logic                  hretrace_pulse,
	input  wire logic                  disp_refresh_pulse,
	input  wire logic                  ext_refresh_pulse,
	input  wire logic                  frame_pulse,
	// Panel and analog controls
	output logic                       lcd_bias_enable_n,
	output logic                       dac_enable,
	output logic                       panel_power_off,
	output dips_pkg::dips_panel_t      panel_ctl,
	output logic                       synth_run,
	// Clock rate and refresh
	output logic                       mem_clk_en,
	output logic                       refresh_alt_src,
	output logic                       cbr_refresh,
	// Host access gates
	output dips_pkg::dips_access_t     host_access
);
	// Software-visible registers
	logic [7:0] interval_ctrl_q;
	logic [7:0] power_mode_q;
	logic [7:0] panel_out_q;
	logic [7:0] panel_pwr_q;
	logic [7:0] ref_count_q;
	logic [7:0] vre_q;

	// Request synchroniser and edges
	logic req_s1_q;
	logic req_s2_q;
	logic req_prev_q;
	logic fall_w;
	logic rise_w;

	// Sequencer state
	dips_pkg::dips_state_t st_q;
	dips_pkg::dips_state_t st_d;
	logic       gen_q;
	logic       div_q;
	logic [1:0] hr_cnt_q;
	logic [1:0] rf_cnt_q;
	logic [1:0] fp_cnt_q;
	logic       counts_done_w;

	// Clock divider and refresh
	logic [2:0] div_cnt_q;
	logic       slow_w;
	logic       pace_run_w;
	logic       pace_strobe;
	logic       pace_window;
	logic       pace_busy;
	logic [8:0] sweep_q;

	// two-flop synchroniser, edges from second stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_s1_q   <= 1'b1;
			req_s2_q   <= 1'b1;
			req_prev_q <= 1'b1;
		end else begin
			req_s1_q   <= powerdown_request_n;
			req_s2_q   <= req_s1_q;
			req_prev_q <= req_s2_q;
		end
	end

	assign fall_w = req_prev_q && !req_s2_q;
	assign rise_w = !req_prev_q && req_s2_q;

	// Register writes; unmapped and read-only offsets ignore writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			interval_ctrl_q <= dips_pkg::REG_RESET_VAL;
			power_mode_q    <= dips_pkg::REG_RESET_VAL;
			panel_out_q     <= dips_pkg::REG_RESET_VAL;
			panel_pwr_q     <= dips_pkg::REG_RESET_VAL;
			ref_count_q     <= dips_pkg::REG_RESET_VAL;
			vre_q           <= dips_pkg::REG_RESET_VAL;
		end else if (reg_write) begin
			case (reg_addr)
				dips_pkg::REFRESH_INTERVAL_CTRL_OFS: interval_ctrl_q <= reg_wdata;
				dips_pkg::POWER_MODE_CTRL_OFS:       power_mode_q    <= reg_wdata;
				dips_pkg::PANEL_OUTPUT_CTRL_OFS:     panel_out_q     <= reg_wdata;
				dips_pkg::PANEL_POWER_CTRL_OFS:      panel_pwr_q     <= reg_wdata;
				dips_pkg::REFRESH_COUNT_CTRL_OFS:    ref_count_q     <= reg_wdata;
				dips_pkg::VRETRACE_END_OFS:          vre_q           <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (sys_rst || !reg_read) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				dips_pkg::REFRESH_INTERVAL_CTRL_OFS: reg_rdata <= interval_ctrl_q;
				dips_pkg::POWER_MODE_CTRL_OFS:       reg_rdata <= power_mode_q;
				dips_pkg::PANEL_OUTPUT_CTRL_OFS:     reg_rdata <= panel_out_q;
				dips_pkg::PANEL_POWER_CTRL_OFS:      reg_rdata <= panel_pwr_q;
				dips_pkg::REFRESH_COUNT_CTRL_OFS:    reg_rdata <= ref_count_q;
				dips_pkg::VRETRACE_END_OFS:          reg_rdata <= vre_q;
				dips_pkg::PD_STATUS_OFS:
					reg_rdata <= {req_s2_q, gen_q, div_q, 2'h0, st_q};
				dips_pkg::SWEEP_COUNT_OFS:           reg_rdata <= sweep_q[7:0];
				default:                             reg_rdata <= 8'h00;
			endcase
		end
	end

	// mode and divide choice latched at request fall
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gen_q <= 1'b0;
			div_q <= 1'b1;
		end else if (fall_w && (st_q == dips_pkg::ST_RUN || st_q == dips_pkg::ST_FPW
				|| st_q == dips_pkg::ST_EXIT)) begin
			// idle selected when mode bit clear
			gen_q <= interval_ctrl_q[dips_pkg::GENERAL_MODE_BIT];
			// general mode divides only on request
			div_q <= !interval_ctrl_q[dips_pkg::GENERAL_MODE_BIT]
				|| power_mode_q[dips_pkg::DIVIDE_EN_BIT];
		end
	end

	// Both counts saturate at two; the wait ends when both reach it
	assign counts_done_w = hr_cnt_q == dips_pkg::ENTRY_EXIT_COUNT
		&& rf_cnt_q == dips_pkg::ENTRY_EXIT_COUNT;

	// Next state of the sequencer
	always_comb begin
		st_d = st_q;
		case (st_q)
			dips_pkg::ST_RUN:   if (fall_w) st_d = dips_pkg::ST_ENTER;
			dips_pkg::ST_ENTER: begin
				if (rise_w)
					st_d = dips_pkg::ST_EXIT;
				else if (counts_done_w)
					st_d = dips_pkg::ST_PD;
			end
			// request rise ends the slowed period
			dips_pkg::ST_PD:    if (rise_w) st_d = dips_pkg::ST_EXIT;
			dips_pkg::ST_EXIT: begin
				if (fall_w)
					st_d = dips_pkg::ST_ENTER;
				// panel resumes after the same counts
				else if (counts_done_w)
					st_d = dips_pkg::ST_FPW;
			end
			dips_pkg::ST_FPW: begin
				if (fall_w)
					st_d = dips_pkg::ST_ENTER;
				else if (fp_cnt_q == dips_pkg::FRAME_PULSE_COUNT)
					st_d = dips_pkg::ST_RUN;
			end
			default:            st_d = dips_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			st_q <= dips_pkg::ST_RUN;
		else
			st_q <= st_d;
	end

	// Retrace and refresh counters restart on every state change
	always_ff @(posedge clk) begin
		if (sys_rst || st_d != st_q) begin
			hr_cnt_q <= 2'h0;
			rf_cnt_q <= 2'h0;
			fp_cnt_q <= 2'h0;
		end else begin
			if (hretrace_pulse && hr_cnt_q != dips_pkg::ENTRY_EXIT_COUNT)
				hr_cnt_q <= hr_cnt_q + 2'h1;
			if (disp_refresh_pulse && rf_cnt_q != dips_pkg::ENTRY_EXIT_COUNT)
				rf_cnt_q <= rf_cnt_q + 2'h1;
			// Only pulses after activity is visible on the pins count
			if (frame_pulse && st_q == dips_pkg::ST_FPW && panel_ctl.active
					&& fp_cnt_q != dips_pkg::FRAME_PULSE_COUNT)
				fp_cnt_q <= fp_cnt_q + 2'h1;
		end
	end

	// enable and DAC drop as entry begins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lcd_bias_enable_n <= 1'b0;
			dac_enable        <= 1'b1;
		end else begin
			lcd_bias_enable_n <= st_d != dips_pkg::ST_RUN;
			dac_enable        <= st_d == dips_pkg::ST_RUN;
		end
	end

	// panel power pin inverted from its bit
	always_ff @(posedge clk) begin
		if (sys_rst)
			panel_power_off <= 1'b1;
		else
			panel_power_off <= !panel_pwr_q[dips_pkg::PANEL_PWR_BIT];
	end

	// tristate bit releases the panel pins
	// driven pins stay low until activity resumes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			panel_ctl <= '0;
		end else begin
			panel_ctl.oe        <= !panel_out_q[dips_pkg::PANEL_TRI_BIT];
			panel_ctl.active    <= st_q == dips_pkg::ST_FPW || st_q == dips_pkg::ST_RUN;
			panel_ctl.force_low <= !(st_q == dips_pkg::ST_FPW || st_q == dips_pkg::ST_RUN);
		end
	end

	// synthesizer never stopped by these modes
	always_ff @(posedge clk) begin
		if (sys_rst)
			synth_run <= 1'b1;
		else
			synth_run <= 1'b1;
	end

	// Slow clocks only in the settled power-down state
	assign slow_w = st_q == dips_pkg::ST_PD && div_q;

	// one enable in eight while slowed
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_cnt_q  <= 3'h0;
			mem_clk_en <= 1'b1;
		end else begin
			div_cnt_q  <= div_cnt_q + 3'h1;
			mem_clk_en <= !slow_w || div_cnt_q == dips_pkg::SLOW_DIVIDE_LAST;
		end
	end

	assign pace_run_w = st_q == dips_pkg::ST_PD && gen_q;

	dips_refresh_pacer #(
		.DOTS_PER_CHAR (dips_pkg::DOTS_PER_CHAR)
	) u_pacer (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.run            (pace_run_w),
		.tick           (mem_clk_en),
		.interval       (interval_ctrl_q[dips_pkg::INTERVAL_MSB:0]),
		.burst_cycles   (dips_pkg::refresh_cycles(ref_count_q[dips_pkg::REF_CNT_MSB:0],
			vre_q[dips_pkg::VRE_REF5_BIT])),
		.refresh_strobe (pace_strobe),
		.refresh_window (pace_window),
		.busy           (pace_busy)
	);

	// idle refresh follows the external input
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			refresh_alt_src <= 1'b0;
			cbr_refresh     <= 1'b0;
		end else begin
			refresh_alt_src <= st_q == dips_pkg::ST_PD;
			cbr_refresh     <= st_q == dips_pkg::ST_PD
				&& (gen_q ? pace_strobe : ext_refresh_pulse);
		end
	end

	// row counter wraps after a full sweep
	always_ff @(posedge clk) begin
		if (sys_rst)
			sweep_q <= 9'h000;
		else if (cbr_refresh)
			sweep_q <= (sweep_q == 9'(dips_pkg::REFRESH_ROWS - 1)) ? 9'h000 : sweep_q + 9'h001;
	end

	// idle blocks memory, palette and mapping RAM
	// general blocks palette, memory only between refreshes
	assign host_access.reg_allow = 1'b1;
	assign host_access.pal_allow = st_q == dips_pkg::ST_RUN;
	assign host_access.mem_allow = st_q == dips_pkg::ST_RUN
		|| (gen_q && !pace_window && !pace_busy);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_lcd_off_entry: assert property (fall_w && st_q == dips_pkg::ST_RUN
		|=> lcd_bias_enable_n && !dac_enable)
		else $error("LCD enable or DAC still on after request fall");
	a_enter_counts: assert property ($rose(st_q == dips_pkg::ST_PD)
		|-> $past(hr_cnt_q) == 2'h2 && $past(rf_cnt_q) == 2'h2)
		else $error("power-down reached before two retraces and refreshes");
	a_slow_divide: assert property (slow_w && div_cnt_q != 3'h7 |=> !mem_clk_en)
		else $error("clock enable not divided by eight");
	a_full_rate_gen: assert property (st_q == dips_pkg::ST_PD && !div_q
		|=> mem_clk_en)
		else $error("general mode slowed without divide enable");
	a_wake_clock: assert property (rise_w |-> ##2 mem_clk_en [*3])
		else $error("full clock rate not restored after request rise");
	a_panel_pwr_pin: assert property (reg_write && reg_addr == 8'h03
		|=> ##1 panel_power_off == !$past(reg_wdata[2], 2))
		else $error("panel power-off pin not inverse of its bit");
	a_lcd_on_fp: assert property ($fell(lcd_bias_enable_n)
		|-> $past(st_q) == dips_pkg::ST_FPW && $past(fp_cnt_q) == 2'h2)
		else $error("LCD enable returned before two frame pulses");
	a_idle_mem_block: assert property (st_q != dips_pkg::ST_RUN && !gen_q
		|-> !host_access.mem_allow && !host_access.pal_allow)
		else $error("idle mode let a memory or palette access through");
	a_idle_refresh: assert property (st_q == dips_pkg::ST_PD && !gen_q
		&& ext_refresh_pulse |=> cbr_refresh)
		else $error("external refresh not passed on in idle mode");
	a_mode_hold: assert property (st_q != dips_pkg::ST_RUN && !fall_w
		|=> gen_q == $past(gen_q))
		else $error("mode changed while powered down");

	c_enter_pd: cover property (fall_w ##[1:300] st_q == dips_pkg::ST_PD);
	c_general_refresh: cover property (pace_run_w && cbr_refresh);
	c_full_wake: cover property (rise_w ##[1:1000] $fell(lcd_bias_enable_n));

endmodule : dips_sequencer

// ==== sim/dips_pm_model.sv ====
// Power manager model: request pin and display timing pulses
`timescale 1ns/1ps
module dips_pm_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Commands from the bench
	input  wire logic sleep_cmd,
	input  wire logic exit_ok,
	// Pins toward the sequencer
	output logic      powerdown_request_n,
	output logic      hretrace_pulse,
	output logic      disp_refresh_pulse,
	output logic      frame_pulse
);
	logic [7:0] tick_q;

	// Free-running timing; spacings of 7, 5 and 20 clocks keep pulses mostly apart
	always_ff @(posedge clk) begin
		tick_q             <= sys_rst ? 8'h00 : tick_q + 8'h01;
		hretrace_pulse     <= (tick_q % 8'h07) == 8'h00;
		disp_refresh_pulse <= (tick_q % 8'h05) == 8'h02;
		frame_pulse        <= (tick_q % 8'h14) == 8'h0B;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			powerdown_request_n <= 1'b1;
		else if (sleep_cmd)
			powerdown_request_n <= 1'b0;
		else if (exit_ok)
			powerdown_request_n <= 1'b1;
	end
endmodule : dips_pm_model

// ==== sim/dips_sequencer_tb_top.sv ====
// Self-checking bench for the power-down sequencer
`timescale 1ns/1ps
module dips_sequencer_tb_top;
	logic                   clk;
	logic                   sys_rst;
	logic [7:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_write;
	logic                   reg_read;
	logic [7:0]             reg_rdata;
	logic                   powerdown_request_n;
	logic                   hretrace_pulse;
	logic                   disp_refresh_pulse;
	logic                   ext_refresh_pulse;
	logic                   frame_pulse;
	logic                   lcd_bias_enable_n;
	logic                   dac_enable;
	logic                   panel_power_off;
	dips_pkg::dips_panel_t  panel_ctl;
	logic                   synth_run;
	logic                   mem_clk_en;
	logic                   refresh_alt_src;
	logic                   cbr_refresh;
	dips_pkg::dips_access_t host_access;
	logic                   sleep_cmd;
	logic                   exit_ok;
	logic [7:0]             rd;
	int                     num_errors;
	int                     num_checks;
	int                     fp_cnt;

	dips_sequencer i_dut (
		.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.powerdown_request_n, .hretrace_pulse, .disp_refresh_pulse, .ext_refresh_pulse,
		.frame_pulse, .lcd_bias_enable_n, .dac_enable, .panel_power_off, .panel_ctl,
		.synth_run, .mem_clk_en, .refresh_alt_src, .cbr_refresh, .host_access
	);

	dips_pm_model i_pm (
		.clk, .sys_rst, .sleep_cmd, .exit_ok, .powerdown_request_n, .hretrace_pulse,
		.disp_refresh_pulse, .frame_pulse
	);

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Frame pulses seen during a wake while the panel runs but its enable is still off
	always @(posedge clk)
		if (exit_ok !== 1'b1)
			fp_cnt = 0;
		else if (panel_ctl.active === 1'b1 && lcd_bias_enable_n === 1'b1 && frame_pulse === 1'b1)
			fp_cnt++;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// Expired wait is a mismatch and ends the run
	task automatic tmo(input int i, input int lim);
		if (i >= lim) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, i, lim);
			tally_and_finish();
		end
	endtask : tmo

	// Step n edges, then sample where outputs are settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : reg_wr

	// Data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_rd

	task automatic sum(input int len, output int n_clk, output int n_mem, output int n_cbr);
		n_clk = 0;
		n_mem = 0;
		n_cbr = 0;
		repeat (len) begin
			cyc(1);
			n_clk += (mem_clk_en === 1'b1);
			n_mem += (host_access.mem_allow === 1'b1);
			n_cbr += (cbr_refresh === 1'b1);
		end
	endtask : sum

	task automatic enter(input logic [7:0] intv, input logic [7:0] pm);
		int i;
		reg_wr(dips_pkg::REFRESH_INTERVAL_CTRL_OFS, intv);
		reg_wr(dips_pkg::POWER_MODE_CTRL_OFS, pm);
		@(posedge clk);
		sleep_cmd <= 1'b1;
		for (i = 0; i < 20 && lcd_bias_enable_n !== 1'b1; i++) cyc(1);
		tmo(i, 20);
		chk(i >= 3 && i <= 6, 1'b1);
		chk(dac_enable, 1'b0);
		for (i = 0; i < 100 && refresh_alt_src !== 1'b1; i++) cyc(1);
		tmo(i, 100);
		chk(i >= 6, 1'b1);
		chk(synth_run, 1'b1);
		reg_wr(dips_pkg::PANEL_OUTPUT_CTRL_OFS, 8'h20);
		reg_wr(dips_pkg::PANEL_POWER_CTRL_OFS, 8'h00);
		cyc(2);
		chk(panel_ctl.oe, 1'b0);
		chk(panel_power_off, 1'b1);
	endtask : enter

	task automatic leave();
		int i;
		reg_wr(dips_pkg::PANEL_POWER_CTRL_OFS, 8'h04);
		reg_wr(dips_pkg::PANEL_OUTPUT_CTRL_OFS, 8'h00);
		cyc(2);
		chk(panel_power_off, 1'b0);
		chk(panel_ctl, 3'b110);
		@(posedge clk);
		sleep_cmd <= 1'b0;
		exit_ok   <= 1'b1;
		cyc(8);
		for (i = 0; i < 8; i++) begin
			chk(mem_clk_en, 1'b1);
			cyc(1);
		end
		for (i = 0; i < 200 && panel_ctl.active !== 1'b1; i++) cyc(1);
		tmo(i, 200);
		chk(lcd_bias_enable_n, 1'b1);
		for (i = 0; i < 200 && lcd_bias_enable_n !== 1'b0; i++) cyc(1);
		tmo(i, 200);
		chk(fp_cnt, 2);
		@(posedge clk);
		exit_ok <= 1'b0;
	endtask : leave

	// One refresh operation of 96 cycles: interval 7 plus 5, eight clocks each
	task automatic measure(input int n_exp);
		int i;
		int n;
		// Start from a host slot so the next strobe opens a burst
		for (i = 0; i < 300 && host_access.mem_allow !== 1'b1; i++) cyc(1);
		tmo(i, 300);
		for (i = 0; i < 300 && cbr_refresh !== 1'b1; i++) cyc(1);
		tmo(i, 300);
		chk(host_access.mem_allow, 1'b0);
		n = 1;
		for (i = 1; i < 96; i++) begin
			cyc(1);
			n += (cbr_refresh === 1'b1);
			if (i == 6)
				chk(cbr_refresh, n_exp > 1);
			if (i == 80)
				chk(host_access.mem_allow, 1'b1);
		end
		cyc(1);
		chk(cbr_refresh, 1'b1);
		chk(n, n_exp);
	endtask : measure

	initial begin
		int k;
		int a;
		int b;
		int c;
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		ext_refresh_pulse = 1'b0;
		sleep_cmd = 1'b0;
		exit_ok = 1'b0;
		num_errors = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(1);
		// Reset levels, register defaults, refused and unmapped places
		chk({lcd_bias_enable_n, dac_enable, panel_power_off, synth_run, mem_clk_en,
			refresh_alt_src, cbr_refresh, host_access.reg_allow}, 8'h79);
		chk({2'b00, panel_ctl, host_access}, 8'h2F);
		for (k = 0; k < 6; k++) begin
			reg_rd(k[7:0], rd);
			chk(rd, dips_pkg::REG_RESET_VAL);
		end
		for (k = 0; k < 5; k++) begin
			reg_wr(k[7:0], (k[7:0] + 8'h01) * 8'h11);
			reg_rd(k[7:0], rd);
			chk(rd, (k[7:0] + 8'h01) * 8'h11);
		end
		chk(panel_power_off, 1'b0);
		reg_wr(dips_pkg::PD_STATUS_OFS, 8'hFF);
		reg_rd(dips_pkg::PD_STATUS_OFS, rd);
		chk(rd, 8'hA0);
		reg_rd(8'h40, rd);
		chk(rd, 8'h00);
		for (k = 0; k < 6; k++)
			reg_wr(k[7:0], 8'h00);
		$display("test registers done");
		// Display idle: divided clocks, memory blocked, external refresh only
		enter(8'h0E, 8'h00);
		sum(64, a, b, c);
		chk(a, 8);
		chk(host_access, 3'b100);
		chk(c, 0);
		@(posedge clk);
		ext_refresh_pulse <= 1'b1;
		@(posedge clk);
		ext_refresh_pulse <= 1'b0;
		#1 chk(cbr_refresh, 1'b1);
		// Mode written while asleep must not take over
		reg_wr(dips_pkg::REFRESH_INTERVAL_CTRL_OFS, 8'h87);
		sum(100, a, b, c);
		chk(b + c, 0);
		reg_rd(dips_pkg::PD_STATUS_OFS, rd);
		chk(rd & 8'h47, 8'h02);
		// Only the one external refresh has reached the row counter so far
		reg_rd(dips_pkg::SWEEP_COUNT_OFS, rd);
		chk(rd, 8'h01);
		leave();
		$display("test display idle done");
		// General mode with divide enabled
		reg_wr(dips_pkg::REFRESH_COUNT_CTRL_OFS, 8'h01);
		enter(8'h87, 8'h40);
		sum(64, a, b, c);
		chk(a, 8);
		chk({host_access.reg_allow, host_access.pal_allow}, 2'b10);
		leave();
		$display("test general divided done");
		// General mode at full rate, every refresh count selection
		for (k = 0; k < 5; k++) begin
			reg_wr(dips_pkg::REFRESH_COUNT_CTRL_OFS, (k == 4) ? 8'h00 : k[7:0]);
			reg_wr(dips_pkg::VRETRACE_END_OFS, (k == 4) ? 8'h40 : 8'h00);
			enter(8'h87, 8'h00);
			sum(64, a, b, c);
			chk(a, 64);
			chk(b > 0, 1'b1);
			measure((k == 4) ? 5 : (k == 3) ? 3 : k + 1);
			leave();
			$display("test general count %0d done", k);
		end
		tally_and_finish();
	end
endmodule : dips_sequencer_tb_top
